// *** rtl/mcu_timing_pkg.sv ***
// shared types and constants of the instruction timing core
package mcu_timing_pkg;

  // ==========================================================
  // timing
  localparam int PHASES_PER_CYCLE = 4;
  localparam int PHASE_W          = 2;
  localparam logic [1:0] PH_FETCH   = 2'h0;
  localparam logic [1:0] PH_OPERAND = 2'h1;
  localparam logic [1:0] PH_EXECUTE = 2'h2;
  localparam logic [1:0] PH_WRITE   = 2'h3;

  // ==========================================================
  // widths and sizes
  localparam int INSTR_W     = 16;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;

  // ==========================================================
  // instruction word fields
  localparam int OPC_MSB  = 15;
  localparam int OPC_LSB  = 11;
  localparam int DEST_BIT = 10;
  localparam int BIT_MSB  = 10;
  localparam int BIT_LSB  = 8;
  localparam int ARG_MSB  = 7;

  // data memory address that aliases the program counter low byte
  localparam logic [7:0] PC_LOW_ADDR = 8'h06;

  // ==========================================================
  // reset values
  localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [INSTR_W-1:0] NOP_WORD  = 16'h0000;

  // ==========================================================
  // operation classes, selected by the top five bits
  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_A, OP_STORE_A, OP_LOAD_IMM,
    OP_ADD, OP_ADD_IMM, OP_ADDC, OP_SUBT, OP_SUBT_IMM, OP_SUBC,
    OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_XOR_IMM,
    OP_INVERT, OP_INCR, OP_DECR, OP_ROR, OP_ROL, OP_RORC, OP_ROLC,
    OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_ZERO, OP_SKIP_BIT_LOW,
    OP_SKIP_BIT_HIGH, OP_BRANCH, OP_CALL, OP_SUB_EXIT, OP_TABLE_READ
  } opcode_t;

  // kind of extra instruction cycle pending
  typedef enum logic [1:0] {
    EX_NONE, EX_BRANCH, EX_SKIP, EX_TABLE
  } extra_t;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              carry;
    logic              setCarry;
    logic              setZero;
  } alu_t;

  typedef struct packed {
    logic [7:0]        addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
  } dmem_req_t;

  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] tableHigh;
    logic              carry;
    logic              zero;
    logic              intEnable;
    logic              retired;
  } core_status_t;

endpackage

// *** rtl/mcu_instruction_timing_core.sv ***
// instruction sequencing, timing and data path of the 8-bit core
//
// Overview of operation
// RULE1 - Work runs in whole instruction cycles of four sys_clk periods.
// RULE2 - Most instructions take one cycle, branch, call, exits and table read two.
// RULE3 - Branch, call, both exits and table read add one cycle.
// RULE4 - A program counter low byte write jumps and costs one more cycle.
// RULE5 - A skip not taken takes one cycle and a taken skip one more.
// RULE6 - Moves go memory to acc, acc to memory, or immediate to acc.
// RULE7 - Add sets carry above 255, subtract sets it as borrow below zero.
// RULE8 - Increment and decrement step by one into memory or accumulator.
// RULE9 - Logic ops set the zero flag on a zero result, else clear it.
// RULE10 - AND, OR and XOR take the accumulator and memory or immediate data; invert takes memory only.
// RULE11 - Rotates shift one bit; via-carry forms pass it through carry.
// RULE12 - A call saves the next address and the matching exit resumes there.
// RULE13 - A branch loads its target and saves no return address.
// RULE14 - A skip tests a memory byte or bit and may skip the next one.
// RULE15 - Bit set and clear change one bit by internal read-modify-write.
// RULE16 - Table read fetches a stored constant from program memory.
// RULE17 - The fetch made during a branch or skip extra cycle is discarded; a table cycle keeps it as the table word.
`timescale 1ns/10ps

module mcu_instruction_timing_core (
  input  wire logic                               sys_clk,
  input  wire logic                               nrst,
  input  wire logic                               clkEn,
  output mcu_timing_pkg::dmem_req_t               dmemReq,
  input  wire logic [mcu_timing_pkg::DATA_W-1:0]  dmemRdData,
  output logic      [mcu_timing_pkg::PC_W-1:0]    progAddr,
  input  wire logic [mcu_timing_pkg::INSTR_W-1:0] progData,
  output mcu_timing_pkg::core_status_t            status,
  output logic      [1:0]                         phase
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]                         phase;
    logic [mcu_timing_pkg::INSTR_W-1:0] instr;
    logic [mcu_timing_pkg::DATA_W-1:0]  operand;
    mcu_timing_pkg::extra_t             extra;
    logic [mcu_timing_pkg::PC_W-1:0]    fetchAddr;
    logic [mcu_timing_pkg::PC_W-1:0]    tableAddr;
    logic [mcu_timing_pkg::STACK_DEPTH-1:0]
          [mcu_timing_pkg::PC_W-1:0]    stack;
    logic [mcu_timing_pkg::SP_W-1:0]    sp;
    mcu_timing_pkg::dmem_req_t          dmem;
    mcu_timing_pkg::core_status_t       stat;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ==========================================================
  // arithmetic and logic unit
  function automatic mcu_timing_pkg::alu_t alu(
    input mcu_timing_pkg::opcode_t            op,
    input logic [mcu_timing_pkg::DATA_W-1:0]  a,
    input logic [mcu_timing_pkg::DATA_W-1:0]  m,
    input logic [mcu_timing_pkg::DATA_W-1:0]  imm,
    input logic                               cin
  );
    mcu_timing_pkg::alu_t r;
    logic [mcu_timing_pkg::DATA_W:0] wide;
    r = '0;
    wide = '0;
    unique case (op)
      // RULE7 carry out of sum
      mcu_timing_pkg::OP_ADD, mcu_timing_pkg::OP_ADD_IMM,
      mcu_timing_pkg::OP_ADDC: begin
        wide = {1'b0, a}
             + {1'b0, (op == mcu_timing_pkg::OP_ADD_IMM) ? imm : m}
             + {8'h00, (op == mcu_timing_pkg::OP_ADDC) & cin};
        r.setCarry = 1'b1;
        r.setZero  = 1'b1;
      end
      // RULE7 borrow below zero
      mcu_timing_pkg::OP_SUBT, mcu_timing_pkg::OP_SUBT_IMM,
      mcu_timing_pkg::OP_SUBC: begin
        wide = {1'b0, a}
             - {1'b0, (op == mcu_timing_pkg::OP_SUBT_IMM) ? imm : m}
             - {8'h00, (op == mcu_timing_pkg::OP_SUBC) & cin};
        r.setCarry = 1'b1;
        r.setZero  = 1'b1;
      end
      // RULE9 RULE10 logic via accumulator, invert on memory only
      mcu_timing_pkg::OP_AND: begin
        wide = {1'b0, a & m};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_AND_IMM: begin
        wide = {1'b0, a & imm};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_OR: begin
        wide = {1'b0, a | m};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_OR_IMM: begin
        wide = {1'b0, a | imm};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_XOR: begin
        wide = {1'b0, a ^ m};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_XOR_IMM: begin
        wide = {1'b0, a ^ imm};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_INVERT: begin
        wide = {1'b0, ~m};
        r.setZero = 1'b1;
      end
      // RULE8 step of one
      mcu_timing_pkg::OP_INCR: begin
        wide = {1'b0, m + 8'h01};
        r.setZero = 1'b1;
      end
      mcu_timing_pkg::OP_DECR: begin
        wide = {1'b0, m - 8'h01};
        r.setZero = 1'b1;
      end
      // RULE11 rotate by one
      mcu_timing_pkg::OP_ROR: wide = {1'b0, m[0], m[7:1]};
      mcu_timing_pkg::OP_ROL: wide = {1'b0, m[6:0], m[7]};
      // RULE11 carry swaps with outgoing bit
      mcu_timing_pkg::OP_RORC: begin
        wide = {m[0], cin, m[7:1]};
        r.setCarry = 1'b1;
      end
      mcu_timing_pkg::OP_ROLC: begin
        wide = {m[7], m[6:0], cin};
        r.setCarry = 1'b1;
      end
      default: wide = {1'b0, m};
    endcase
    r.res   = wide[7:0];
    r.carry = wide[8];
    return r;
  endfunction

  // ==========================================================
  // next state
  mcu_timing_pkg::opcode_t            op;
  mcu_timing_pkg::alu_t               aluOut;
  logic                               toMem;
  logic [7:0]                         bitMask;
  logic [mcu_timing_pkg::DATA_W-1:0]  wrValue;
  logic                               doWrite;
  logic                               skipTaken;
  logic [mcu_timing_pkg::PC_W-1:0]    pcPlusOne;

  always_comb begin
    state_next = state_reg;
    op         = mcu_timing_pkg::opcode_t'(
                   state_reg.instr[mcu_timing_pkg::OPC_MSB:
                                   mcu_timing_pkg::OPC_LSB]);
    toMem      = state_reg.instr[mcu_timing_pkg::DEST_BIT];
    bitMask    = 8'h01 << state_reg.instr[mcu_timing_pkg::BIT_MSB:
                                          mcu_timing_pkg::BIT_LSB];
    aluOut     = alu(op, state_reg.stat.acc, state_reg.operand,
                     state_reg.instr[mcu_timing_pkg::ARG_MSB:0],
                     state_reg.stat.carry);
    wrValue    = '0;
    doWrite    = 1'b0;
    skipTaken  = 1'b0;
    pcPlusOne  = state_reg.stat.pc + 11'h001;
    // RULE1 four phases per cycle
    state_next.phase = state_reg.phase + 2'h1;
    unique case (state_reg.phase)
      mcu_timing_pkg::PH_FETCH: begin
        // RULE16 constant from program memory
        if (state_reg.extra == mcu_timing_pkg::EX_TABLE) begin
          state_next.stat.acc       = progData[7:0];
          state_next.stat.tableHigh = progData[15:8];
        end else if (state_reg.extra == mcu_timing_pkg::EX_NONE) begin
          state_next.instr    = progData;
          state_next.dmem.addr = progData[mcu_timing_pkg::ARG_MSB:0];
        end else begin
          // RULE17 fetch of the extra cycle dropped
          state_next.instr = mcu_timing_pkg::NOP_WORD;
        end
      end
      mcu_timing_pkg::PH_OPERAND: begin
        // the counter low byte is not in data memory, so it is aliased
        state_next.operand =
          (state_reg.dmem.addr == mcu_timing_pkg::PC_LOW_ADDR)
            ? state_reg.stat.pc[7:0] : dmemRdData;
      end
      mcu_timing_pkg::PH_EXECUTE: begin
        state_next.stat.retired = state_reg.extra == mcu_timing_pkg::EX_NONE;
        if (state_reg.extra != mcu_timing_pkg::EX_NONE) begin
          // RULE5 skip resumes past the dropped one
          if (state_reg.extra == mcu_timing_pkg::EX_SKIP)
            state_next.stat.pc = pcPlusOne;
          state_next.extra = mcu_timing_pkg::EX_NONE;
        end else begin
          state_next.stat.pc = pcPlusOne;
          unique case (op)
            // RULE6 three transfer forms
            mcu_timing_pkg::OP_LOAD_A:
              state_next.stat.acc = state_reg.operand;
            mcu_timing_pkg::OP_STORE_A: begin
              wrValue = state_reg.stat.acc;
              doWrite = 1'b1;
            end
            mcu_timing_pkg::OP_LOAD_IMM:
              state_next.stat.acc =
                state_reg.instr[mcu_timing_pkg::ARG_MSB:0];
            mcu_timing_pkg::OP_ADD, mcu_timing_pkg::OP_ADDC,
            mcu_timing_pkg::OP_SUBT, mcu_timing_pkg::OP_SUBC,
            mcu_timing_pkg::OP_AND, mcu_timing_pkg::OP_OR,
            mcu_timing_pkg::OP_XOR, mcu_timing_pkg::OP_INVERT,
            mcu_timing_pkg::OP_INCR, mcu_timing_pkg::OP_DECR,
            mcu_timing_pkg::OP_ROR, mcu_timing_pkg::OP_ROL,
            mcu_timing_pkg::OP_RORC, mcu_timing_pkg::OP_ROLC: begin
              // RULE8 result to memory or accumulator
              if (toMem) begin
                wrValue = aluOut.res;
                doWrite = 1'b1;
              end else begin
                state_next.stat.acc = aluOut.res;
              end
            end
            mcu_timing_pkg::OP_ADD_IMM, mcu_timing_pkg::OP_SUBT_IMM,
            mcu_timing_pkg::OP_AND_IMM, mcu_timing_pkg::OP_OR_IMM,
            mcu_timing_pkg::OP_XOR_IMM:
              state_next.stat.acc = aluOut.res;
            // RULE15 other bits kept
            mcu_timing_pkg::OP_BIT_SET: begin
              wrValue = state_reg.operand | bitMask;
              doWrite = 1'b1;
            end
            mcu_timing_pkg::OP_BIT_CLEAR: begin
              wrValue = state_reg.operand & ~bitMask;
              doWrite = 1'b1;
            end
            // RULE14 byte or bit test
            mcu_timing_pkg::OP_SKIP_ZERO: begin
              skipTaken = state_reg.operand == 8'h00;
              if (toMem)
                state_next.stat.acc = state_reg.operand;
            end
            mcu_timing_pkg::OP_SKIP_BIT_LOW:
              skipTaken = (state_reg.operand & bitMask) == 8'h00;
            mcu_timing_pkg::OP_SKIP_BIT_HIGH:
              skipTaken = (state_reg.operand & bitMask) != 8'h00;
            // RULE13 RULE3 target, no save
            mcu_timing_pkg::OP_BRANCH: begin
              state_next.stat.pc =
                state_reg.instr[mcu_timing_pkg::PC_W-1:0];
              state_next.extra = mcu_timing_pkg::EX_BRANCH;
            end
            // RULE12 RULE3 save next address
            mcu_timing_pkg::OP_CALL: begin
              state_next.stack[state_reg.sp] = pcPlusOne;
              state_next.sp = state_reg.sp + 3'h1;
              state_next.stat.pc =
                state_reg.instr[mcu_timing_pkg::PC_W-1:0];
              state_next.extra = mcu_timing_pkg::EX_BRANCH;
            end
            // RULE12 RULE3 resume saved address
            mcu_timing_pkg::OP_SUB_EXIT: begin
              state_next.sp = state_reg.sp - 3'h1;
              state_next.stat.pc = state_reg.stack[state_reg.sp - 3'h1];
              state_next.extra = mcu_timing_pkg::EX_BRANCH;
              if (toMem)
                state_next.stat.intEnable = 1'b1;
            end
            // RULE2 RULE3 table read second cycle
            mcu_timing_pkg::OP_TABLE_READ: begin
              state_next.tableAddr =
                {state_reg.instr[mcu_timing_pkg::BIT_MSB:
                                 mcu_timing_pkg::BIT_LSB],
                 state_reg.operand};
              state_next.extra = mcu_timing_pkg::EX_TABLE;
            end
            mcu_timing_pkg::OP_NOP: begin
            end
          endcase
          if (aluOut.setCarry)
            state_next.stat.carry = aluOut.carry;
          // RULE9 zero flag follows result
          if (aluOut.setZero)
            state_next.stat.zero = aluOut.res == 8'h00;
          // RULE5 taken skip costs a cycle
          if (skipTaken)
            state_next.extra = mcu_timing_pkg::EX_SKIP;
          // RULE4 low byte write is a jump
          if (doWrite &&
              state_reg.dmem.addr == mcu_timing_pkg::PC_LOW_ADDR) begin
            state_next.stat.pc = {state_reg.stat.pc[10:8], wrValue};
            state_next.extra   = mcu_timing_pkg::EX_BRANCH;
          end else if (doWrite) begin
            state_next.dmem.wdata = wrValue;
            state_next.dmem.we    = 1'b1;
          end
        end
      end
      mcu_timing_pkg::PH_WRITE: begin
        state_next.dmem.we      = 1'b0;
        state_next.stat.retired = 1'b0;
        // RULE2 table cycle reads the table word
        state_next.fetchAddr =
          (state_reg.extra == mcu_timing_pkg::EX_TABLE)
            ? state_reg.tableAddr : state_reg.stat.pc;
      end
    endcase
  end

  // ==========================================================
  // registers; clkEn low freezes everything
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg            <= '0;
      state_reg.stat.pc    <= mcu_timing_pkg::PC_RESET;
      state_reg.stat.acc   <= mcu_timing_pkg::ACC_RESET;
      state_reg.fetchAddr  <= mcu_timing_pkg::PC_RESET;
      state_reg.instr      <= mcu_timing_pkg::NOP_WORD;
      state_reg.extra      <= mcu_timing_pkg::EX_NONE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign dmemReq  = state_reg.dmem;
  assign progAddr = state_reg.fetchAddr;
  assign status   = state_reg.stat;
  assign phase    = state_reg.phase;

endmodule

// *** bench/mcu_timing_core_props.sv ***
// port checker for the instruction timing core
`timescale 1ns/10ps

module mcu_timing_core_props (
  input wire logic                               sys_clk,
  input wire logic                               nrst,
  input wire logic                               clkEn,
  input wire mcu_timing_pkg::dmem_req_t          dmemReq,
  input wire logic [mcu_timing_pkg::DATA_W-1:0]  dmemRdData,
  input wire logic [mcu_timing_pkg::PC_W-1:0]    progAddr,
  input wire logic [mcu_timing_pkg::INSTR_W-1:0] progData,
  input wire mcu_timing_pkg::core_status_t       status,
  input wire logic [1:0]                         phase
);
  // ==========================================================
  // fetch tracking
  logic [4:0]  opReg;
  logic [10:0] argReg;
  logic [7:0]  rdReg;
  logic [7:0]  accReg;
  logic        ctlReg;
  logic        plainReg;

  // stale fetches judged only when retired
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      opReg    <= 5'h00;
      argReg   <= 11'h000;
      rdReg    <= 8'h00;
      accReg   <= 8'h00;
      ctlReg   <= 1'b0;
      plainReg <= 1'b0;
    end else if (clkEn) begin
      if (phase == mcu_timing_pkg::PH_FETCH) begin
        opReg  <= progData[15:11];
        argReg <= progData[10:0];
      end
      if (phase == mcu_timing_pkg::PH_OPERAND) begin
        rdReg  <= dmemRdData;
        accReg <= status.acc;
      end
      if (phase == mcu_timing_pkg::PH_WRITE) begin
        ctlReg   <= status.retired && (opReg inside {
                    mcu_timing_pkg::OP_BRANCH, mcu_timing_pkg::OP_CALL,
                    mcu_timing_pkg::OP_SUB_EXIT,
                    mcu_timing_pkg::OP_TABLE_READ});
        plainReg <= status.retired && (opReg inside {mcu_timing_pkg::OP_NOP,
                    mcu_timing_pkg::OP_LOAD_IMM, mcu_timing_pkg::OP_ADD_IMM});
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  phase_wrap_a: assert property (
    clkEn && phase == 2'h3 |=> phase == 2'h0)
    else $error("no phase wrap");
  phase_freeze_a: assert property (
    !clkEn |=> $stable(phase) && $stable(progAddr))
    else $error("moved while frozen");
  fetch_hold_a: assert property (
    phase != mcu_timing_pkg::PH_WRITE |=> $stable(progAddr))
    else $error("fetch address moved");
  write_slot_a: assert property (
    dmemReq.we |-> phase == mcu_timing_pkg::PH_WRITE)
    else $error("write off slot");
  retire_slot_a: assert property (
    status.retired |-> phase == mcu_timing_pkg::PH_WRITE)
    else $error("retire off slot");
  single_cycle_a: assert property (
    phase == mcu_timing_pkg::PH_WRITE && plainReg |-> status.retired)
    else $error("idle after plain op");
  extra_cycle_a: assert property (
    phase == mcu_timing_pkg::PH_WRITE && ctlReg |-> !status.retired)
    else $error("no extra cycle");
  pc_low_guard_a: assert property (
    dmemReq.we |-> dmemReq.addr != mcu_timing_pkg::PC_LOW_ADDR)
    else $error("pc byte written");
  imm_load_a: assert property (
    status.retired && opReg == mcu_timing_pkg::OP_LOAD_IMM
    |-> status.acc == argReg[7:0])
    else $error("bad immediate");
  add_carry_a: assert property (
    status.retired && opReg == mcu_timing_pkg::OP_ADD_IMM
    |-> status.carry == ((9'(accReg) + 9'(argReg[7:0])) > 9'h0ff))
    else $error("bad carry");
  zero_flag_a: assert property (
    status.retired && (opReg inside {mcu_timing_pkg::OP_AND_IMM,
    mcu_timing_pkg::OP_OR_IMM, mcu_timing_pkg::OP_XOR_IMM})
    |-> status.zero == (status.acc == 8'h00))
    else $error("bad zero");
  bit_set_a: assert property (
    status.retired && opReg == mcu_timing_pkg::OP_BIT_SET
    |-> dmemReq.we && dmemReq.wdata == (rdReg | (8'h01 << argReg[10:8])))
    else $error("bad bit set");

  cover property (status.retired && opReg == mcu_timing_pkg::OP_CALL);
  cover property (status.retired && opReg == mcu_timing_pkg::OP_TABLE_READ);
  cover property (dmemReq.we && opReg == mcu_timing_pkg::OP_BIT_CLEAR);
endmodule

bind mcu_instruction_timing_core mcu_timing_core_props props_u (
  .sys_clk    (sys_clk),
  .nrst       (nrst),
  .clkEn      (clkEn),
  .dmemReq    (dmemReq),
  .dmemRdData (dmemRdData),
  .progAddr   (progAddr),
  .progData   (progData),
  .status     (status),
  .phase      (phase)
);

// *** bench/tb.sv ***
// self-checking bench for the instruction timing core
`timescale 1ns/10ps

module tb;
  // ==========================================================
  // ports and memories
  logic                               sys_clk = 1'b0;
  logic                               nrst = 1'b0;
  logic                               clkEn = 1'b1;
  mcu_timing_pkg::dmem_req_t          dmemReq;
  logic [mcu_timing_pkg::DATA_W-1:0]  dmemRdData;
  logic [mcu_timing_pkg::PC_W-1:0]    progAddr;
  logic [mcu_timing_pkg::INSTR_W-1:0] progData;
  mcu_timing_pkg::core_status_t       status;
  logic [1:0]                         phase;
  logic [15:0]                        pmem [0:2047];
  logic [7:0]                         dmem [0:255];
  logic [9:0]                         seen [$];
  logic [9:0]                         want [$];
  int                                 retCnt;
  int                                 failures = 0;
  int                                 checks = 0;

  always #12.5 sys_clk = ~sys_clk;
  assign progData   = pmem[progAddr];
  assign dmemRdData = dmem[dmemReq.addr];
  always @(posedge sys_clk) begin
    if (nrst && dmemReq.we === 1'b1) begin
      dmem[dmemReq.addr] <= dmemReq.wdata;
    end
  end

  mcu_instruction_timing_core dut_u (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .clkEn      (clkEn),
    .dmemReq    (dmemReq),
    .dmemRdData (dmemRdData),
    .progAddr   (progAddr),
    .progData   (progData),
    .status     (status),
    .phase      (phase)
  );

  // ==========================================================
  // helpers
  function automatic logic [15:0] mk(mcu_timing_pkg::opcode_t op,
                                     logic [10:0] arg);
    return {op, arg};
  endfunction

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // cleared off the edge
  task automatic boot();
    pmem = '{default: 16'h0000};
    dmem = '{default: 8'h00};
    @(posedge sys_clk);
    nrst <= 1'b0;
    clkEn <= 1'b1;
    #1;
  endtask

  task automatic go();
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    retCnt = 0;
  endtask

  // four clocks per cycle
  task automatic step(int n);
    repeat (4 * n) begin
      @(posedge sys_clk);
      if (status.retired === 1'b1) retCnt++;
    end
    #1;
  endtask

  task automatic walk(int n);
    seen = {};
    repeat (n) begin
      step(1);
      seen.push_back({status.zero, status.carry, status.acc});
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic arith_case();
    boot();
    dmem[8'h21] = 8'h81;
    dmem[8'h30] = 8'hff;
    dmem[8'h32] = 8'h05;
    dmem[8'h33] = 8'h7f;
    pmem[0]  = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h0f0);
    pmem[1]  = mk(mcu_timing_pkg::OP_STORE_A, 11'h020);
    pmem[2]  = mk(mcu_timing_pkg::OP_LOAD_A, 11'h021);
    pmem[3]  = mk(mcu_timing_pkg::OP_ADD_IMM, 11'h07f);
    pmem[4]  = mk(mcu_timing_pkg::OP_SUBT_IMM, 11'h001);
    pmem[5]  = mk(mcu_timing_pkg::OP_INCR, 11'h030);
    pmem[6]  = mk(mcu_timing_pkg::OP_DECR, 11'h431);
    pmem[7]  = mk(mcu_timing_pkg::OP_ADDC, 11'h032);
    pmem[8]  = mk(mcu_timing_pkg::OP_SUBC, 11'h032);
    pmem[9]  = mk(mcu_timing_pkg::OP_SUBT, 11'h032);
    pmem[10] = mk(mcu_timing_pkg::OP_ADD, 11'h032);
    pmem[11] = mk(mcu_timing_pkg::OP_INCR, 11'h433);
    pmem[12] = mk(mcu_timing_pkg::OP_BRANCH, 11'h00c);
    want = '{10'h0f0, 10'h0f0, 10'h081, 10'h300, 10'h1ff, 10'h300,
             10'h100, 10'h006, 10'h001, 10'h1fc, 10'h101, 10'h101};
    go();
    walk(12);
    foreach (want[i]) chk("arith flags", 16'(seen[i]), 16'(want[i]));
    chk("stored acc", 16'(dmem[8'h20]), 16'h00f0);
    chk("decrement", 16'(dmem[8'h31]), 16'h00ff);
    chk("increment", 16'(dmem[8'h33]), 16'h0080);
    chk("retired", 16'(retCnt), 16'h000c);
  endtask

  task automatic logic_case();
    boot();
    dmem[8'h34] = 8'h80;
    dmem[8'h35] = 8'h02;
    pmem[0]  = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h00f);
    pmem[1]  = mk(mcu_timing_pkg::OP_AND_IMM, 11'h0f0);
    pmem[2]  = mk(mcu_timing_pkg::OP_OR_IMM, 11'h081);
    pmem[3]  = mk(mcu_timing_pkg::OP_ROLC, 11'h034);
    pmem[4]  = mk(mcu_timing_pkg::OP_RORC, 11'h035);
    pmem[5]  = mk(mcu_timing_pkg::OP_ROL, 11'h034);
    pmem[6]  = mk(mcu_timing_pkg::OP_ROR, 11'h035);
    pmem[7]  = mk(mcu_timing_pkg::OP_INVERT, 11'h034);
    pmem[8]  = mk(mcu_timing_pkg::OP_XOR_IMM, 11'h07f);
    pmem[9]  = mk(mcu_timing_pkg::OP_OR, 11'h035);
    pmem[10] = mk(mcu_timing_pkg::OP_AND, 11'h034);
    pmem[11] = mk(mcu_timing_pkg::OP_XOR, 11'h035);
    pmem[12] = mk(mcu_timing_pkg::OP_BRANCH, 11'h00c);
    want = '{10'h00f, 10'h200, 10'h081, 10'h100, 10'h081, 10'h001,
             10'h001, 10'h07f, 10'h200, 10'h002, 10'h200, 10'h002};
    go();
    walk(12);
    foreach (want[i]) chk("logic flags", 16'(seen[i]), 16'(want[i]));
  endtask

  task automatic skip_case();
    boot();
    dmem[8'h40] = 8'h5a;
    pmem[0] = mk(mcu_timing_pkg::OP_BIT_SET, 11'h040);
    pmem[1] = mk(mcu_timing_pkg::OP_BIT_CLEAR, 11'h340);
    pmem[2] = mk(mcu_timing_pkg::OP_SKIP_BIT_HIGH, 11'h040);
    pmem[3] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h0ee);
    pmem[4] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h001);
    pmem[5] = mk(mcu_timing_pkg::OP_SKIP_ZERO, 11'h041);
    pmem[6] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h0dd);
    pmem[7] = mk(mcu_timing_pkg::OP_SKIP_BIT_LOW, 11'h040);
    pmem[8] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h002);
    pmem[9] = mk(mcu_timing_pkg::OP_BRANCH, 11'h009);
    go();
    step(8);
    chk("acc mid skips", 16'(status.acc), 16'h0001);
    step(1);
    chk("acc end skips", 16'(status.acc), 16'h0002);
    chk("bit byte", 16'(dmem[8'h40]), 16'h0053);
    chk("retired", 16'(retCnt), 16'h0007);
  endtask

  task automatic call_case();
    boot();
    pmem[0] = mk(mcu_timing_pkg::OP_CALL, 11'h040);
    pmem[1] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h011);
    pmem[2] = mk(mcu_timing_pkg::OP_BRANCH, 11'h002);
    pmem[11'h040] = mk(mcu_timing_pkg::OP_SUB_EXIT, 11'h400);
    go();
    step(4);
    chk("acc in call", 16'(status.acc), 16'h0000);
    chk("int enable", 16'(status.intEnable), 16'h0001);
    step(1);
    chk("acc on return", 16'(status.acc), 16'h0011);
    chk("retired", 16'(retCnt), 16'h0003);
  endtask

  task automatic jump_case();
    boot();
    dmem[8'h06] = 8'h77;
    dmem[8'h23] = 8'h23;
    pmem[0] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h010);
    pmem[1] = mk(mcu_timing_pkg::OP_STORE_A, 11'h006);
    pmem[2] = mk(mcu_timing_pkg::OP_LOAD_IMM, 11'h0ee);
    pmem[11'h010] = mk(mcu_timing_pkg::OP_TABLE_READ, 11'h123);
    pmem[11'h011] = mk(mcu_timing_pkg::OP_BRANCH, 11'h011);
    pmem[11'h123] = 16'hbeef;
    go();
    step(3);
    chk("acc after jump", 16'(status.acc), 16'h0010);
    chk("memory byte", 16'(dmem[8'h06]), 16'h0077);
    step(2);
    chk("table low", 16'(status.acc), 16'h00ef);
    chk("table high", 16'(status.tableHigh), 16'h00be);
    chk("retired", 16'(retCnt), 16'h0003);
  endtask

  task automatic freeze_case();
    boot();
    go();
    step(1);
    @(posedge sys_clk);
    clkEn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("frozen phase", 16'(phase), 16'h0001);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("phase resumed", 16'(phase), 16'h0000);
    chk("next fetch", 16'(progAddr), 16'h0002);
  endtask

  // ==========================================================
  // verdict
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    arith_case();
    logic_case();
    skip_case();
    call_case();
    jump_case();
    freeze_case();
    test_done();
  end
endmodule
